// ### core/imu_framer_pkg.sv
// Purpose: types shared by the sample sequencer and framer
// Assumes: nothing beyond the constants header
// Notes:   channels are x rate, x accel, y rate, y accel, z rate, z accel, aux volts, temperature
package imu_framer_pkg;

   // ----------------------------------------------------------------
   // sample and message carriers
   // ----------------------------------------------------------------
   typedef logic signed [23:0] sample_t;
   typedef sample_t [7:0]      sensors_t;
   typedef logic signed [26:0] accum_t;
   typedef accum_t [5:0]       deltas_t;

   typedef struct packed {
      logic [15:0] startup;
      logic [15:0] oper;
      logic [15:0] err;
   } bit_flags_t;

   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;

endpackage

// ### core/imu_framer_regs.svh
// Purpose: timing counts, field positions and constants of the sample sequencer and framer
// Assumes: 10 MHz master clock
// Notes:   definitions only
`ifndef IMU_FRAMER_REGS_SVH
`define IMU_FRAMER_REGS_SVH

// ----------------------------------------------------------------
// clock and sampling timing
// ----------------------------------------------------------------
`define CLK_HZ          10000000
`define SAMPLE_RATE_HZ  1000
`define CYCLE_CLKS      (`CLK_HZ / `SAMPLE_RATE_HZ)
`define SAMPLE_GAP      8
`define N_CH            8
`define N_INERTIAL      6
`define LAST_TICK       ((`N_INERTIAL - 1) * `SAMPLE_GAP)
`define TX_TICK         (`LAST_TICK + 1)
`define FILT_TICK       (`N_CH * `SAMPLE_GAP)
`define ACC_TICK        (`FILT_TICK + 1)
`define SCHED_CYCLES    5
`define FILT_SHIFT      2

// ----------------------------------------------------------------
// serial line
// ----------------------------------------------------------------
`define BAUD            460800
`define BIT_CLKS        ((`CLK_HZ + `BAUD / 2) / `BAUD)
`define STOP_BITS       2

// ----------------------------------------------------------------
// message layout and scaling
// ----------------------------------------------------------------
`define HEADER_WORD     16'h55AA
`define W_COUNT         1
`define W_DATA          2
`define W_BIT           30
`define CKSUM_WORD      33
`define MSG_BYTES       68
`define DATA_FRAC       12
`define DT_FRAC         20
`define DT_DEG_Q        16'h0419
`define DT_MPS_Q        16'h282B

`endif

// ### core/imu_sample_sequencer_framer.sv
// Purpose: 1 kHz sample sequencer, low-pass filter, five-cycle schedule and serial message framer
// Assumes: sensor values are signed counts with DATA_FRAC fraction bits, stable while sampled
// Notes:   run-mode pin is pulled up outside, so a floating pin reads high
//
// Functional notes
// [R1] sample every channel once per 1 kHz cycle
// [R2] sync high at cycle start, low after last
// [R3] second-order low-pass per channel at sample rate
// [R4] five-cycle schedule: compensate, apply, deltas, transmit
// [R5] message starts after cycle-five sync falls
// [R6] message data captured while cycle-three sync high
// [R7] word zero is header 0x55AA
// [R8] word one is 16-bit message counter
// [R9] words 2-13 six rate/accel floats
// [R10] words 14-17 aux voltage, temperature floats
// [R11] words 18-29 delta angle/velocity floats per axis
// [R12] words 30-32 startup, operation, error flags
// [R13] last word is two's complement checksum
// [R14] counter increments per sent message, wraps
// [R15] 460800 baud, start, eight data, two stops
// [R16] words sent most significant byte first
// [R17] one message per five-cycle schedule
// [R18] run-mode low: finish current message, then stop
`include "imu_framer_regs.svh"

module imu_sample_sequencer_framer
   import imu_framer_pkg::*;
#(
   parameter int CYCLE_CLKS = `CYCLE_CLKS
)
(
   input  wire logic       I_MCLK,
   input  wire logic       I_NRST,
   input  wire sensors_t   I_SENSOR,
   input  wire sensors_t   I_BIAS,
   input  wire bit_flags_t I_BIT_FLAGS,
   input  wire logic       I_RUN_MODE,
   output logic            O_SYNC,
   output logic            O_TX,
   output logic            O_TX_BUSY,
   output logic [2:0]      O_SCHED_CYCLE
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // one section of the filter: y += 0.75 * (x - y)
   function automatic sample_t filt_step(input sample_t y, input sample_t x);
      logic signed [24:0] d;
      logic signed [24:0] s;
      d = 25'(x) - 25'(y);
      s = 25'(y) + d - (d >>> `FILT_SHIFT);
      filt_step = s[23:0];
   endfunction

   // signed fixed point with frac fraction bits to single float, truncating
   function automatic logic [31:0] to_float(input logic signed [47:0] v, input logic [5:0] frac);
      logic [47:0] mag;
      logic [5:0]  msb;
      logic [47:0] norm;
      logic [7:0]  ex;
      mag = v[47] ? 48'(-v) : 48'(v);
      msb = 6'h00;
      for (int i = 0; i < 48; i++)
      begin
         if (mag[i])
            msb = 6'(i);
      end
      norm = mag << (6'd47 - msb);
      ex = 8'(8'h7F + {2'b00, msb} - {2'b00, frac});
      to_float = (mag == 48'h0) ? 32'h0000_0000 : {v[47], ex, norm[46:24]};
   endfunction

   // ----------------------------------------------------------------
   // run-mode pin synchroniser
   // ----------------------------------------------------------------
   logic run_meta_r;
   logic run_sync_r;

   always_ff @(posedge I_MCLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         run_meta_r <= 1'b0;
         run_sync_r <= 1'b0;
      end
      else
      begin
         run_meta_r <= I_RUN_MODE;
         run_sync_r <= run_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // sampling cycle and schedule counters
   // ----------------------------------------------------------------
   logic [13:0] tick_r;
   logic [2:0]  phase_r;
   logic        sync_r;
   wire         tick_wrap  = (tick_r == 14'(CYCLE_CLKS - 1));
   wire  [2:0]  sample_ch  = 3'(tick_r / `SAMPLE_GAP);
   wire         sample_hit = (tick_r < 14'(`FILT_TICK)) && (tick_r % `SAMPLE_GAP == 0); // R1
   wire         filt_hit   = (tick_r == 14'(`FILT_TICK));
   wire         acc_hit    = (tick_r == 14'(`ACC_TICK));

   // sync rises at cycle start, falls once the last inertial channel is taken
   wire sync_nxt = (tick_r == 14'h0000) ? 1'b1 :
                   (tick_r == 14'(`LAST_TICK)) ? 1'b0 : sync_r; // R2

   always_ff @(posedge I_MCLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         tick_r  <= 14'h0000;
         phase_r <= 3'h0;
         sync_r  <= 1'b0;
      end
      else
      begin
         tick_r  <= tick_wrap ? 14'h0000 : tick_r + 14'h0001; // R1
         sync_r  <= sync_nxt; // R2
         if (tick_wrap)
            phase_r <= (phase_r == 3'(`SCHED_CYCLES - 1)) ? 3'h0 : phase_r + 3'h1; // R4
      end
   end

   // ----------------------------------------------------------------
   // sampling, filtering and compensation
   // ----------------------------------------------------------------
   sensors_t raw_r;
   sensors_t flt1_r;
   sensors_t flt2_r;
   sensors_t bias_r;
   sensors_t comp;
   sensors_t data_snap_r;
   deltas_t  acc_r;
   deltas_t  delta_snap_r;

   // compensated values follow the filter output; bias only changes in cycle two
   always_comb
   begin
      for (int c = 0; c < `N_CH; c++)
         comp[c] = flt2_r[c] - bias_r[c];
   end

   always_ff @(posedge I_MCLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         raw_r  <= '0;
         flt1_r <= '0;
         flt2_r <= '0;
         bias_r <= '0;
      end
      else
      begin
         if (sample_hit)
            raw_r[sample_ch] <= I_SENSOR[sample_ch]; // R1
         for (int c = 0; c < `N_CH; c++)
         begin
            if (filt_hit)
            begin
               flt1_r[c] <= filt_step(flt1_r[c], raw_r[c]); // R3
               flt2_r[c] <= filt_step(flt2_r[c], flt1_r[c]); // R3
            end
         end
         if (filt_hit && phase_r == 3'h1)
            bias_r <= I_BIAS; // R4
      end
   end

   // snapshot in cycle three while sync is high; deltas close in cycle four
   always_ff @(posedge I_MCLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         data_snap_r  <= '0;
         acc_r        <= '0;
         delta_snap_r <= '0;
      end
      else
      begin
         if (phase_r == 3'h2 && tick_r == 14'h0001)
            data_snap_r <= comp; // R6
         for (int j = 0; j < `N_INERTIAL; j++)
         begin
            if (acc_hit && phase_r == 3'h3)
            begin
               delta_snap_r[j] <= acc_r[j] + 27'(comp[j]); // R4
               acc_r[j]        <= '0;
            end
            else if (acc_hit)
               acc_r[j] <= acc_r[j] + 27'(comp[j]);
         end
      end
   end

   // ----------------------------------------------------------------
   // message word selection
   // ----------------------------------------------------------------
   tx_state_t   state_r;
   tx_state_t   state_nxt;
   logic [6:0]  byte_idx_r;
   logic [15:0] sum_r;
   logic [15:0] count_r;
   bit_flags_t  flags_r;

   wire [5:0]  word_idx  = byte_idx_r[6:1];
   wire [5:0]  item_off  = word_idx - 6'(`W_DATA);
   wire [3:0]  item      = item_off[4:1];
   wire [2:0]  dsel      = 3'(item - 4'h8);
   wire        is_angle  = ~dsel[0];
   wire [15:0] dt_q      = is_angle ? `DT_DEG_Q : `DT_MPS_Q;
   wire signed [47:0] delta_val = 48'(delta_snap_r[dsel]) * $signed({1'b0, dt_q});
   wire signed [47:0] data_val  = 48'(data_snap_r[item[2:0]]);
   wire        is_delta  = item[3];
   wire [31:0] flt_word  = is_delta ? to_float(delta_val, 6'(`DATA_FRAC + `DT_FRAC)) // R11
                                    : to_float(data_val, 6'(`DATA_FRAC)); // R9 R10
   wire [15:0] flt_half  = item_off[0] ? flt_word[15:0] : flt_word[31:16]; // R16

   // word mux over the fixed message layout
   wire [15:0] cur_word =
      (word_idx == 6'h00)                 ? `HEADER_WORD : // R7
      (word_idx == 6'(`W_COUNT))          ? count_r : // R8
      (word_idx < 6'(`W_BIT))             ? flt_half :
      (word_idx == 6'(`W_BIT))            ? flags_r.startup : // R12
      (word_idx == 6'(`W_BIT + 1))        ? flags_r.oper : // R12
      (word_idx == 6'(`W_BIT + 2))        ? flags_r.err : // R12
                                            16'(-sum_r); // R13
   wire [7:0]  cur_byte = byte_idx_r[0] ? cur_word[7:0] : cur_word[15:8]; // R16

   // ----------------------------------------------------------------
   // serial transmitter
   // ----------------------------------------------------------------
   logic [4:0] baud_cnt_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic       tx_r;

   // run mode is only looked at here, so a message in flight always completes
   wire start_msg = (phase_r == 3'h4) && (tick_r == 14'(`TX_TICK)) && !sync_r
                    && run_sync_r && (state_r == TX_IDLE); // R5 R17 R18
   wire bit_done  = (baud_cnt_r == 5'h00);
   wire last_data = (bit_cnt_r == 4'h7);
   wire last_stop = (bit_cnt_r == 4'(`STOP_BITS - 1));
   wire last_byte = (byte_idx_r == 7'(`MSG_BYTES - 1));
   wire load_byte = (state_r == TX_START) && bit_done;
   wire msg_done  = (state_r == TX_STOP) && bit_done && last_stop && last_byte;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         TX_IDLE:
            if (start_msg)
               state_nxt = TX_START;
         TX_START:
            if (bit_done)
               state_nxt = TX_DATA;
         TX_DATA:
            if (bit_done && last_data)
               state_nxt = TX_STOP;
         TX_STOP:
            if (bit_done && last_stop)
               state_nxt = last_byte ? TX_IDLE : TX_START;
         default:
            state_nxt = TX_IDLE;
      endcase
   end

   // bit timing and shifting; data bits go out least significant first
   always_ff @(posedge I_MCLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         state_r    <= TX_IDLE;
         baud_cnt_r <= 5'h00;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         tx_r       <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_nxt != state_r || (state_r != TX_IDLE && bit_done))
            baud_cnt_r <= 5'(`BIT_CLKS - 1); // R15
         else if (state_r != TX_IDLE)
            baud_cnt_r <= baud_cnt_r - 5'h01;
         if (state_nxt != state_r)
            bit_cnt_r <= 4'h0;
         else if (bit_done && state_r != TX_IDLE)
            bit_cnt_r <= bit_cnt_r + 4'h1;
         if (load_byte)
            shift_r <= cur_byte;
         else if (state_r == TX_DATA && bit_done)
            shift_r <= {1'b0, shift_r[7:1]};
         case (state_nxt)
            TX_START: tx_r <= 1'b0; // R15
            TX_DATA:  tx_r <= load_byte ? cur_byte[0] : (bit_done ? shift_r[1] : tx_r); // R15
            default:  tx_r <= 1'b1; // R15
         endcase
      end
   end

   // byte position, running sum, counter and flag capture
   always_ff @(posedge I_MCLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         byte_idx_r <= 7'h00;
         sum_r      <= 16'h0000;
         count_r    <= 16'h0000;
         flags_r    <= '0;
      end
      else
      begin
         if (start_msg)
         begin
            byte_idx_r <= 7'h00;
            sum_r      <= 16'h0000;
            flags_r    <= I_BIT_FLAGS; // R12
         end
         else if ((state_r == TX_STOP) && bit_done && last_stop && !last_byte)
            byte_idx_r <= byte_idx_r + 7'h01;
         if (load_byte && !byte_idx_r[0] && word_idx < 6'(`CKSUM_WORD))
            sum_r <= sum_r + cur_word; // R13
         if (msg_done)
            count_r <= count_r + 16'h0001; // R14
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign O_SYNC        = sync_r;
   assign O_TX          = tx_r;
   assign O_TX_BUSY     = (state_r != TX_IDLE);
   assign O_SCHED_CYCLE = phase_r + 3'h1;

endmodule // imu_sample_sequencer_framer

// ### verif/host_serial_rx.sv
// Purpose: host receiver model, samples the line mid-bit
// Assumes: 22 clocks a bit, line idles high
// Notes:   only listens, so it drives nothing back
module host_serial_rx
(
   input  wire logic  i_clk,
   input  wire logic  i_line,
   output logic [7:0] o_byte,
   output logic       o_strobe,
   output logic       o_frame_err
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // byte receiver
   // ------------------------------------------------------------
   // mid-bit sampling tolerates the edge landing on a clock edge
   initial
   begin
      o_byte = 8'h00;
      o_strobe = 1'b0;
      o_frame_err = 1'b0;
      forever
      begin
         @(negedge i_line);
         repeat (11) @(posedge i_clk);
         if (i_line !== 1'b0) o_frame_err = 1'b1;
         for (int i = 0; i < 8; i++)
         begin
            repeat (22) @(posedge i_clk);
            o_byte[i] = i_line;
         end
         for (int i = 0; i < 2; i++)
         begin
            repeat (22) @(posedge i_clk);
            if (i_line !== 1'b1) o_frame_err = 1'b1;
         end
         o_strobe <= 1'b1;
         @(posedge i_clk);
         o_strobe <= 1'b0;
      end
   end
endmodule // host_serial_rx

// ### verif/imu_framer_props.sv
// Purpose: timing checks on the sync, schedule and serial ports
// Assumes: one clock, asynchronous active-low reset
// Notes:   68 bytes of 11 bits, 22 clocks a bit
module imu_framer_props
   import imu_framer_pkg::*;
#(
   parameter int CYCLE_CLKS = 10000
)
(
   input wire logic       I_MCLK,
   input wire logic       I_NRST,
   input wire logic       O_SYNC,
   input wire logic       O_TX,
   input wire logic       O_TX_BUSY,
   input wire logic [2:0] O_SCHED_CYCLE
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // helper counters
   // ------------------------------------------------------------
   logic sync_q_r;
   logic seen_r;
   int   per_r;
   int   hi_r;
   int   busy_r;
   wire  sync_rise = O_SYNC & ~sync_q_r;

   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_NRST);

   // spans too long to unroll, so counted here
   always_ff @(posedge I_MCLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         sync_q_r <= 1'b0;
         seen_r   <= 1'b0;
         per_r    <= 0;
         hi_r     <= 0;
         busy_r   <= 0;
      end
      else
      begin
         sync_q_r <= O_SYNC;
         seen_r   <= seen_r | sync_rise;
         per_r    <= sync_rise ? 1 : per_r + 1;
         hi_r     <= O_SYNC ? hi_r + 1 : 0;
         busy_r   <= O_TX_BUSY ? busy_r + 1 : 0;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sync_period_a: assert property (sync_rise && seen_r |-> per_r == CYCLE_CLKS)
      else $error("sync period wrong");
   sync_width_a: assert property ($fell(O_SYNC) |-> hi_r == 40)
      else $error("sync width wrong");
   sched_step_a: assert property ($changed(O_SCHED_CYCLE) |-> O_SCHED_CYCLE ==
      (($past(O_SCHED_CYCLE) == 3'h5) ? 3'h1 : $past(O_SCHED_CYCLE) + 3'h1)) else $error("schedule step wrong");
   msg_slot_a: assert property ($rose(O_TX_BUSY) |-> O_SCHED_CYCLE == 3'h5)
      else $error("message outside cycle five");
   tx_after_a: assert property ($rose(O_TX_BUSY) |-> $past(O_SYNC, 2) && !$past(O_SYNC))
      else $error("message not after sync fall");
   start_bit_a: assert property ($rose(O_TX_BUSY) |-> !O_TX [*8])
      else $error("start bit missing");
   tx_idle_a: assert property (!O_TX_BUSY |-> O_TX)
      else $error("line not idle high");
   msg_len_a: assert property ($fell(O_TX_BUSY) |-> busy_r == 16456)
      else $error("message length wrong");
endmodule // imu_framer_props

// ### verif/imu_sample_sequencer_framer_bench.sv
// Purpose: self-checking bench for the sequencer and framer
// Assumes: short schedule cycle, host receiver model on the line
// Notes:   only aux volts and temperature carry a few counts, so deltas and inertial floats read zero
module imu_sample_sequencer_framer_bench;
   import imu_framer_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // signals and helpers
   // ------------------------------------------------------------
   // 17000 clocks a schedule just holds one 16456-clock message
   localparam int         CYC  = 3400;
   localparam bit_flags_t FL_A = {16'h1234, 16'h5678, 16'h9ABC};
   localparam bit_flags_t FL_B = {16'hFEDC, 16'h0F0F, 16'h8001};
`define CHECK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("BAD %s expected %h seen %h", what, exp, got); end end
   logic        I_MCLK = 1'b0;
   logic        I_NRST = 1'b0;
   // steps under four counts settle through both filter sections in two updates
   sensors_t    I_SENSOR = {24'h000003, 24'h000002, {6{24'h000000}}};
   sensors_t    I_BIAS = '0;
   bit_flags_t  I_BIT_FLAGS = FL_A;
   logic        I_RUN_MODE = 1'b1;
   logic        O_SYNC, O_TX, O_TX_BUSY, rx_stb, rx_err;
   logic [2:0]  O_SCHED_CYCLE;
   logic [7:0]  rx_byte;
   logic [7:0]  rx_q[$];
   logic [15:0] w[34];
   int          num_errors = 0;
   int          check_count = 0;

   always #50 I_MCLK = ~I_MCLK;
   always @(posedge I_MCLK) if (rx_stb === 1'b1) rx_q.push_back(rx_byte);

   imu_sample_sequencer_framer #(.CYCLE_CLKS(CYC)) i_dut (.I_MCLK(I_MCLK), .I_NRST(I_NRST),
      .I_SENSOR(I_SENSOR), .I_BIAS(I_BIAS), .I_BIT_FLAGS(I_BIT_FLAGS), .I_RUN_MODE(I_RUN_MODE),
      .O_SYNC(O_SYNC), .O_TX(O_TX), .O_TX_BUSY(O_TX_BUSY), .O_SCHED_CYCLE(O_SCHED_CYCLE));
   host_serial_rx i_host (.i_clk(I_MCLK), .i_line(O_TX), .o_byte(rx_byte), .o_strobe(rx_stb),
      .o_frame_err(rx_err));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one whole message, judged word by word
   task automatic get_msg(input logic [15:0] cnt, input bit_flags_t fl);
      logic [15:0] sum = 16'h0000;
      logic [15:0] fexp;
      rx_q.delete();
      for (int n = 0; n < 40000 && rx_q.size() < 68; n++) @(posedge I_MCLK);
      `CHECK("byte count", 68, rx_q.size())
      for (int i = 0; i < 34; i++) w[i] = {rx_q[2*i], rx_q[2*i+1]};
      `CHECK("header", 16'h55AA, w[0])
      `CHECK("counter", cnt, w[1])
      // aux 2 counts is 2^-11, temperature 3 counts is 1.5 * 2^-11; low halves are zero
      for (int i = 2; i < 30; i++)
      begin
         fexp = (i == 14) ? 16'h3A00 : ((i == 16) ? 16'h3A40 : 16'h0000);
         `CHECK("float word", fexp, w[i])
      end
      `CHECK("startup flags", fl.startup, w[30])
      `CHECK("oper flags", fl.oper, w[31])
      `CHECK("error flags", fl.err, w[32])
      for (int i = 0; i < 33; i++) sum += w[i];
      `CHECK("checksum", 16'h0000 - sum, w[33])
      `CHECK("frame error", 1'b0, rx_err)
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      repeat (6) @(posedge I_MCLK);
      `CHECK("sync in reset", 1'b0, O_SYNC)
      `CHECK("line in reset", 1'b1, O_TX)
      `CHECK("busy in reset", 1'b0, O_TX_BUSY)
      `CHECK("cycle in reset", 3'h1, O_SCHED_CYCLE)
      I_NRST <= 1'b1;
   endtask

   task automatic t_first_msg();
      get_msg(16'h0000, FL_A);
   endtask

   // run pin drops mid-message, then one slot is refused
   task automatic t_run_low();
      logic seen = 1'b0;
      I_BIT_FLAGS <= FL_B;
      // the previous message still sends its last stop bit here
      for (int n = 0; n < 100 && O_TX_BUSY !== 1'b0; n++) @(posedge I_MCLK);
      for (int n = 0; n < 20000 && O_TX_BUSY !== 1'b1; n++) @(posedge I_MCLK);
      I_RUN_MODE <= 1'b0;
      get_msg(16'h0001, FL_B);
      for (int n = 0; n < 100 && O_TX_BUSY !== 1'b0; n++) @(posedge I_MCLK);
      repeat (17000)
      begin
         @(posedge I_MCLK);
         if (O_TX_BUSY !== 1'b0) seen = 1'b1;
      end
      `CHECK("refused message", 1'b0, seen)
      I_RUN_MODE <= 1'b1;
      get_msg(16'h0002, FL_B);
   endtask

   initial
   begin
      t_reset();
      t_first_msg();
      t_run_low();
      wrap_up();
   end

   // watchdog, well past the five schedules the run needs
   initial
   begin
      repeat (100000) @(posedge I_MCLK);
      num_errors++;
      wrap_up();
   end
endmodule // imu_sample_sequencer_framer_bench

bind imu_sample_sequencer_framer imu_framer_props #(.CYCLE_CLKS(CYCLE_CLKS)) i_props (.I_MCLK(I_MCLK),
   .I_NRST(I_NRST), .O_SYNC(O_SYNC), .O_TX(O_TX), .O_TX_BUSY(O_TX_BUSY), .O_SCHED_CYCLE(O_SCHED_CYCLE));
